/* sgl_bucket_segment_decoder.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - bucket length bytes 11..8 counts discarded bytes
// - zero-length bucket is valid, discards nothing
// - destination bucket drops bytes, writes none
// - source-side bucket acts as length zero
// - destination buckets count toward total, not blocks
// - type nibble 1h marks a bit bucket
// - type nibble 2h marks a segment pointer
// - sub-type zero gives absolute next-segment address
// - sub-type one gives offset, not address
// - address plus length past 2^64 is error
// - after segment pointer, more segments follow
// - type 3h means final; nesting there errors
// - type 0h is a data block descriptor
module sgl_bucket_segment_decoder
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [sgl_dec_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [sgl_dec_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic      [1:0]                    bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [sgl_dec_pkg::ADDR_W-1:0] araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic      [sgl_dec_pkg::DATA_W-1:0] rdata,
  output logic      [1:0]                    rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic                               irq
);
  import sgl_dec_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [DATA_W-1:0] desc_q [DESC_WORDS];
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              dest_q;
  logic              start_q;
  logic              final_q;
  res_t              result_q;
  logic [31:0]       discard_q;
  logic [63:0]       next_addr_q;
  logic [31:0]       next_len_q;
  logic [NUM_EV-1:0] stat_q;
  logic [NUM_EV-1:0] mask_q;
  logic              do_wr;
  logic              do_rd;
  logic              wr_ctrl;
  logic              restart;
  logic              wr_ok;
  desc_t             d;
  logic              is_data;
  logic              is_bucket;
  logic              is_seg;
  logic              is_last;
  logic              over;
  logic              len_inv;
  logic              nest;
  logic [31:0]       eff_len;
  logic [31:0]       total_q;
  logic [31:0]       lbc_q;
  logic [NUM_EV-1:0] ev;
  logic [DATA_W-1:0] rd_mux;
  logic              rd_ok;

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  // address and data are taken in either order, held until both are here
  assign awready = !aw_have_q;
  assign wready  = !w_have_q;
  assign do_wr   = aw_have_q && w_have_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      waddr_q   <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_have_q <= 1'b1;
      waddr_q   <= awaddr;
    end
    else if (do_wr)
      aw_have_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (wvalid && wready)
    begin
      w_have_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end
    else if (do_wr)
      w_have_q <= 1'b0;
  end

  // write decode; unmapped and read-only words answer slverr
  always_comb
  begin
    case (waddr_q)
      OFF_DESC0, OFF_DESC1, OFF_DESC2, OFF_DESC3,
      OFF_CTRL, OFF_INT_STAT, OFF_INT_MASK: wr_ok = 1'b1;
      default:                               wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  // descriptor words honour byte strobes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DESC_WORDS; i++)
        desc_q[i] <= '0;
    end
    else if (do_wr && (waddr_q <= OFF_DESC3))
    begin
      for (int b = 0; b < 4; b++)
        if (wstrb_q[b])
          desc_q[waddr_q[3:2]][b*8 +: 8] <= wdata_q[b*8 +: 8];
    end
  end

  // ------------------------------------------------------------
  // control: direction level, start and restart pulses
  // ------------------------------------------------------------
  assign wr_ctrl = do_wr && (waddr_q == OFF_CTRL) && wstrb_q[0];
  assign restart = wr_ctrl && wdata_q[CTRL_RESTART];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dest_q  <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= wr_ctrl && wdata_q[CTRL_START];
      if (wr_ctrl)
        dest_q <= wdata_q[CTRL_DEST];
    end
  end

  // ------------------------------------------------------------
  // descriptor decode
  // ------------------------------------------------------------
  // reserved bytes live in d.rsvd and in addr of a bucket; nothing reads them
  assign d         = desc_t'({desc_q[3], desc_q[2], desc_q[1], desc_q[0]});
  assign is_data   = (d.dtype == TYPE_DATA);
  assign is_bucket = (d.dtype == TYPE_BUCKET);
  assign is_seg    = (d.dtype == TYPE_SEG);
  assign is_last   = (d.dtype == TYPE_LAST);

  // a bucket on the source side behaves as if its length were zero
  assign eff_len = (is_bucket && !dest_q) ? '0 : d.len;

  sgl_range_check #(
    .AW   (64)
  ) u_range (
    .addr (d.addr),
    .len  (d.len),
    .over (over)
  );

  // buckets carry no address, so only addressed kinds can overflow
  assign len_inv = over && (is_data || is_seg || is_last);
  // a segment or last pointer inside the final segment is illegal
  assign nest    = final_q && (is_seg || is_last);

  // bytes to drop for this descriptor; zero length drops nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      discard_q <= '0;
    else if (start_q)
      discard_q <= is_bucket ? eff_len : '0;
  end

  // next-segment pointer; sub-type picks absolute address or offset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      next_addr_q <= '0;
      next_len_q  <= '0;
    end
    else if (start_q && (is_seg || is_last) && !len_inv && !nest)
    begin
      next_addr_q <= d.addr;
      next_len_q  <= d.len;
    end
  end

  // chain walk: last pointer arms final state, restart disarms it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
      final_q <= 1'b0;
    else if (start_q && is_last && !nest)
      final_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_q <= '0;
    else if (start_q)
    begin
      result_q.dtype       <= d.dtype;
      result_q.sub         <= d.sub;
      result_q.is_data     <= is_data;
      result_q.is_bucket   <= is_bucket;
      result_q.is_seg      <= is_seg;
      result_q.is_last     <= is_last;
      result_q.offset_mode <= (is_seg || is_last) && (d.sub == SUB_OFFSET);
      result_q.expect_more <= is_seg;
      result_q.in_final    <= final_q || is_last;
      result_q.len_invalid <= len_inv;
      result_q.nest_err    <= nest;
    end
  end

  // ------------------------------------------------------------
  // length accounting
  // ------------------------------------------------------------
  // total counts data and destination buckets; block count skips buckets
  sgl_len_acc #(
    .W       (32)
  ) u_total (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (restart),
    .add_en  (start_q && (is_data || is_bucket) && !len_inv),
    .add_val (eff_len),
    .sum_q   (total_q)
  );

  sgl_len_acc #(
    .W       (32)
  ) u_lbc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (restart),
    .add_en  (start_q && is_data && !len_inv),
    .add_val (d.len),
    .sum_q   (lbc_q)
  );

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  assign ev[EV_DONE]    = start_q;
  assign ev[EV_LEN_INV] = start_q && len_inv;
  assign ev[EV_NEST]    = start_q && nest;

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= '0;
    else if (do_wr && (waddr_q == OFF_INT_STAT) && wstrb_q[0])
      stat_q <= (stat_q & ~wdata_q[NUM_EV-1:0]) | ev;
    else
      stat_q <= stat_q | ev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_q <= '0;
    else if (do_wr && (waddr_q == OFF_INT_MASK) && wstrb_q[0])
      mask_q <= wdata_q[NUM_EV-1:0];
  end

  assign irq = |(stat_q & mask_q);

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  assign arready = !rvalid_q;
  assign do_rd   = arvalid && arready;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_comb
  begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    case (araddr)
      OFF_DESC0:    rd_mux = desc_q[0];
      OFF_DESC1:    rd_mux = desc_q[1];
      OFF_DESC2:    rd_mux = desc_q[2];
      OFF_DESC3:    rd_mux = desc_q[3];
      OFF_CTRL:     rd_mux[CTRL_DEST] = dest_q;
      OFF_RESULT:   rd_mux[RES_W-1:0] = result_q;
      OFF_DISCARD:  rd_mux = discard_q;
      OFF_TOTAL:    rd_mux = total_q;
      OFF_LBC:      rd_mux = lbc_q;
      OFF_NEXT_LO:  rd_mux = next_addr_q[31:0];
      OFF_NEXT_HI:  rd_mux = next_addr_q[63:32];
      OFF_NEXT_LEN: rd_mux = next_len_q;
      OFF_INT_STAT: rd_mux[NUM_EV-1:0] = stat_q;
      OFF_INT_MASK: rd_mux[NUM_EV-1:0] = mask_q;
      default:      rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (do_rd)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_bucket_src_zero;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_bucket && !dest_q |=> (discard_q == '0);
  endproperty
  a_bucket_src_zero: assert property (p_bucket_src_zero) else $error("source bucket discarded bytes");

  property p_bucket_dest_len;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_bucket && dest_q |=> (discard_q == $past(d.len)) && result_q.is_bucket;
  endproperty
  a_bucket_dest_len: assert property (p_bucket_dest_len) else $error("destination bucket count wrong");

  property p_total_bucket;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_bucket && dest_q && !restart |=> (total_q == $past(total_q) + $past(d.len));
  endproperty
  a_total_bucket: assert property (p_total_bucket) else $error("bucket length not in total");

  property p_lbc_bucket;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_bucket && !restart |=> $stable(lbc_q);
  endproperty
  a_lbc_bucket: assert property (p_lbc_bucket) else $error("bucket counted in block count");

  property p_seg_more;
    @(posedge aclk) disable iff (!aresetn)
    start_q && (d.dtype == TYPE_SEG) |=> result_q.expect_more && result_q.is_seg;
  endproperty
  a_seg_more: assert property (p_seg_more) else $error("segment did not expect more");

  property p_seg_offset;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_seg && (d.sub == SUB_OFFSET) |=> result_q.offset_mode;
  endproperty
  a_seg_offset: assert property (p_seg_offset) else $error("offset sub-type not flagged");

  property p_seg_addr;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_seg && (d.sub == SUB_ADDR) && !len_inv && !nest |=> (next_addr_q == $past(d.addr)) && !result_q.offset_mode;
  endproperty
  a_seg_addr: assert property (p_seg_addr) else $error("next segment address wrong");

  property p_len_inv;
    @(posedge aclk) disable iff (!aresetn)
    start_q && is_seg && ({1'b0, d.addr} + {33'h0, d.len} > {1'b1, 64'h0}) |=> stat_q[EV_LEN_INV] ##1 stat_q[EV_LEN_INV];
  endproperty
  a_len_inv: assert property (p_len_inv) else $error("overflow not flagged");

  property p_nest;
    @(posedge aclk) disable iff (!aresetn)
    start_q && final_q && is_seg |=> result_q.nest_err && stat_q[EV_NEST];
  endproperty
  a_nest: assert property (p_nest) else $error("nested pointer in final segment");

  property p_done_irq;
    @(posedge aclk) disable iff (!aresetn)
    start_q && mask_q[EV_DONE] && !(do_wr && (waddr_q == OFF_INT_MASK)) |=> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done did not raise interrupt");

endmodule : sgl_bucket_segment_decoder
`default_nettype wire

/* sgl_bucket_segment_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sgl_bucket_segment_decoder_test;
  import sgl_dec_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, put, dest;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rng_q, v, tot_e, lbc_e, mask_e;
  logic [3:0]  wstrb, put_idx, get_idx;
  logic [1:0]  bresp, rresp, r;
  logic        fin_e;
  desc_t       put_desc, get_desc, d;
  int          n_mismatch, checks_done;

  sgl_bucket_segment_decoder sgl_bucket_segment_decoder_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));
  sgl_host_mem sgl_host_mem_i (.aclk(aclk), .put(put), .put_idx(put_idx), .put_desc(put_desc),
    .get_idx(get_idx), .get_desc(get_desc));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rng_q ^= rng_q << 13;
    rng_q ^= rng_q >> 17;
    rng_q ^= rng_q << 5;
    return rng_q;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s exp %h got %h", what, exp, got);
    end
  endtask : check

  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s);
    bit aw_q, w_q;
    aw_q = 0;
    w_q = 0;
    awaddr <= a;
    wdata <= dat;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_q && w_q))
    begin
      @(posedge aclk);
      aw_q |= awready;
      w_q |= wready;
      awvalid <= !aw_q;
      wvalid <= !w_q;
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(what, exp, v);
  endtask : rc

  function automatic res_t exp_res(desc_t x, logic fin);
    res_t e;
    e = '0;
    e.dtype = x.dtype;
    e.sub = x.sub;
    e.is_data = x.dtype == TYPE_DATA;
    e.is_bucket = x.dtype == TYPE_BUCKET;
    e.is_seg = x.dtype == TYPE_SEG;
    e.is_last = x.dtype == TYPE_LAST;
    e.offset_mode = (e.is_seg || e.is_last) && x.sub == SUB_OFFSET;
    e.len_invalid = !e.is_bucket && ({1'b0, x.addr} + {33'h0, x.len} > {1'b1, 64'h0});
    e.nest_err = fin && (e.is_seg || e.is_last);
    e.expect_more = e.is_seg && !e.len_invalid && !e.nest_err;
    e.in_final = fin || (e.is_last && !e.len_invalid && !e.nest_err);
    return e;
  endfunction : exp_res

  // load, start, then compare result, totals, status, irq and the words that apply to the type against the model
  task automatic decode(input desc_t x, input logic dst, input logic rst);
    res_t        e;
    logic [31:0] msk;
    logic        ok;
    if (rst)
    begin
      tot_e = 0;
      lbc_e = 0;
      fin_e = 0;
    end
    e = exp_res(x, fin_e);
    ok = !e.len_invalid && !e.nest_err;
    for (int k = 0; k < DESC_WORDS; k++)
      wr(8'(4 * k), x[32*k +: 32], 4'hf);
    wr(OFF_INT_STAT, 32'h7, 4'hf);
    wr(OFF_CTRL, {29'h0, rst, dst, 1'b1}, 4'hf);
    fin_e = e.in_final;
    if (ok)
    begin
      tot_e += (e.is_data || (e.is_bucket && dst)) ? x.len : 32'h0;
      lbc_e += e.is_data ? x.len : 32'h0;
    end
    // expect-more and final-state bits are left open for faulty descriptors
    msk = ok ? 32'h1ffff : 32'h1fff3;
    rd(OFF_RESULT);
    check("result", 32'(e) & msk, v & msk);
    rc("total", OFF_TOTAL, tot_e);
    rc("lbc", OFF_LBC, lbc_e);
    if (e.is_bucket)
      rc("discard", OFF_DISCARD, dst ? x.len : 32'h0);
    if ((e.is_seg || e.is_last) && ok)
    begin
      rc("next_lo", OFF_NEXT_LO, x.addr[31:0]);
      rc("next_hi", OFF_NEXT_HI, x.addr[63:32]);
      rc("next_len", OFF_NEXT_LEN, x.len);
    end
    rc("int_stat", OFF_INT_STAT, {29'h0, e.nest_err, e.len_invalid, 1'b1});
    check("irq", {31'h0, |(mask_e[2:0] & {e.nest_err, e.len_invalid, 1'b1})}, {31'h0, irq});
  endtask : decode

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // the run needs a few thousand cycles, allow far more
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    {rng_q, n_mismatch, checks_done} = {32'd85457, 64'd0};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, put, awaddr, araddr} = '0;
    {wdata, wstrb, put_idx, get_idx, put_desc, mask_e, tot_e, lbc_e, fin_e} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("result_rst", OFF_RESULT, 32'h0);
    rc("int_rst", OFF_INT_STAT, 32'h0);
    rc("unmapped", 8'h3c, 32'h0);
    check("unmapped_resp", 32'(RESP_SLVERR), 32'(r));
    wr(OFF_RESULT, 32'h5, 4'hf);
    check("ro_resp", 32'(RESP_SLVERR), 32'(r));
    wr(OFF_DESC0, 32'hffffffff, 4'hf);
    wr(OFF_DESC0, 32'h0, 4'h1);
    rc("strobe", OFF_DESC0, 32'hffffff00);
    $display("test registers done");
    // final segment, bucket and data accumulate, nested segment, overflowing segment
    mask_e = 32'h4;
    wr(OFF_INT_MASK, mask_e, 4'hf);
    decode({TYPE_LAST, SUB_ADDR, 24'h0, 32'h40, 64'h1000}, 1'b1, 1'b1);
    decode({TYPE_BUCKET, SUB_ADDR, 24'hffffff, 32'h5, 64'hffffffffffffffff}, 1'b1, 1'b0);
    decode({TYPE_DATA, SUB_ADDR, 24'h0, 32'h7, 64'h2000}, 1'b0, 1'b0);
    decode({TYPE_SEG, SUB_OFFSET, 24'h0, 32'h20, 64'h3000}, 1'b0, 1'b0);
    decode({TYPE_SEG, SUB_ADDR, 24'h0, 32'h10, 64'hfffffffffffffff8}, 1'b0, 1'b1);
    wr(OFF_INT_STAT, 32'h7, 4'hf);
    check("irq_clear", 32'h0, {31'h0, irq});
    $display("test chain done");
    // random descriptors fetched from host memory, with boundary cases
    for (int i = 0; i < 48; i++)
    begin
      d = {rnd(), rnd(), rnd(), rnd()};
      d.dtype = 4'(rnd() % 4);
      d.sub = 4'(rnd() % 2);
      if (i % 4 == 1)
        d.len = 32'h0;
      dest = 1'(rnd() % 2);
      mask_e = 32'(rnd() % 8);
      put_idx <= 4'(i);
      put_desc <= d;
      put <= 1'b1;
      @(posedge aclk);
      put <= 1'b0;
      get_idx <= 4'(i);
      @(posedge aclk);
      d = get_desc;
      if (i % 4 == 2)
        d.addr = 64'h0 - {32'h0, d.len} + 64'(i % 8 == 6);
      wr(OFF_INT_MASK, mask_e, 4'hf);
      decode(d, dest, 1'b1);
    end
    $display("test random done");
    finish_test();
  end
endmodule : sgl_bucket_segment_decoder_test
`default_nettype wire

/* sgl_dec_pkg.sv */
`default_nettype none
package sgl_dec_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFF_DESC0    = 8'h00;
  localparam logic [7:0]  OFF_DESC1    = 8'h04;
  localparam logic [7:0]  OFF_DESC2    = 8'h08;
  localparam logic [7:0]  OFF_DESC3    = 8'h0c;
  localparam logic [7:0]  OFF_CTRL     = 8'h10;
  localparam logic [7:0]  OFF_RESULT   = 8'h14;
  localparam logic [7:0]  OFF_DISCARD  = 8'h18;
  localparam logic [7:0]  OFF_TOTAL    = 8'h1c;
  localparam logic [7:0]  OFF_LBC      = 8'h20;
  localparam logic [7:0]  OFF_NEXT_LO  = 8'h24;
  localparam logic [7:0]  OFF_NEXT_HI  = 8'h28;
  localparam logic [7:0]  OFF_NEXT_LEN = 8'h2c;
  localparam logic [7:0]  OFF_INT_STAT = 8'h30;
  localparam logic [7:0]  OFF_INT_MASK = 8'h34;
  localparam int          DESC_WORDS   = 4;

  // ------------------------------------------------------------
  // control bits, event bits, bus answers
  // ------------------------------------------------------------
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_DEST    = 1;
  localparam int          CTRL_RESTART = 2;
  localparam int          EV_DONE      = 0;
  localparam int          EV_LEN_INV   = 1;
  localparam int          EV_NEST      = 2;
  localparam int          NUM_EV       = 3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------
  // descriptor encodings
  // ------------------------------------------------------------
  localparam logic [3:0]  TYPE_DATA    = 4'h0;
  localparam logic [3:0]  TYPE_BUCKET  = 4'h1;
  localparam logic [3:0]  TYPE_SEG     = 4'h2;
  localparam logic [3:0]  TYPE_LAST    = 4'h3;
  localparam logic [3:0]  SUB_ADDR     = 4'h0;
  localparam logic [3:0]  SUB_OFFSET   = 4'h1;

  // 16-byte descriptor, byte 15 on top
  typedef struct packed {
    logic [3:0]  dtype;
    logic [3:0]  sub;
    logic [23:0] rsvd;
    logic [31:0] len;
    logic [63:0] addr;
  } desc_t;

  // decode outcome, read back as one word
  typedef struct packed {
    logic [3:0] dtype;
    logic [3:0] sub;
    logic       is_data;
    logic       is_bucket;
    logic       is_seg;
    logic       is_last;
    logic       offset_mode;
    logic       expect_more;
    logic       in_final;
    logic       len_invalid;
    logic       nest_err;
  } res_t;

  localparam int          RES_W        = $bits(res_t);

endpackage : sgl_dec_pkg
`default_nettype wire

/* sgl_host_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module sgl_host_mem
(
  input  wire logic               aclk,
  input  wire logic               put,
  input  wire logic [3:0]         put_idx,
  input  wire sgl_dec_pkg::desc_t put_desc,
  input  wire logic [3:0]         get_idx,
  output var  sgl_dec_pkg::desc_t get_desc
);
  import sgl_dec_pkg::*;
  desc_t mem_q [16];
  desc_t fix_d;
  // ----------------------------------------
  // descriptor slots in host memory
  // ----------------------------------------
  // a host never hands out an empty or ragged segment
  always_comb
  begin
    fix_d = put_desc;
    if (put_desc.dtype == TYPE_SEG || put_desc.dtype == TYPE_LAST)
    begin
      fix_d.len = {put_desc.len[31:4], 4'h0};
      if (fix_d.len == 32'h0)
        fix_d.len = 32'h10;
    end
  end
  // slots are written one per clock
  always_ff @(posedge aclk)
    if (put)
      mem_q[put_idx] <= fix_d;
  assign get_desc = mem_q[get_idx];
endmodule : sgl_host_mem
`default_nettype wire

/* sgl_len_acc.sv */
`timescale 1ns/1ps
`default_nettype none
module sgl_len_acc
#(
  parameter int W = 32
)
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          clr,
  input  wire logic          add_en,
  input  wire logic [31:0]   add_val,
  output logic      [W-1:0]  sum_q
);
  import sgl_dec_pkg::*;

  // clear beats add so a restart starts from zero; wraps on overflow
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
      sum_q <= '0;
    else if (add_en)
      sum_q <= W'(sum_q + W'(add_val));
  end

endmodule : sgl_len_acc
`default_nettype wire

/* sgl_range_check.sv */
`timescale 1ns/1ps
`default_nettype none
module sgl_range_check
#(
  parameter int AW = 64
)
(
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   len,
  output logic               over
);
  import sgl_dec_pkg::*;

  logic [AW:0] sum;

  // one carry bit past the address space; exactly the top is still legal
  assign sum  = {1'b0, addr} + (AW+1)'(len);
  assign over = sum[AW] && (|sum[AW-1:0]);

endmodule : sgl_range_check
`default_nettype wire
